// file: verilog/tps_top.sv
// Test access port with shared GPIO pads and a core-side data stream
`timescale 1ns/1ps
`include "tps_regs.svh"
// Functional notes
// - Sample data input on rising test clock
// - Drive data output only in shift states
// - Sample mode select on rising test clock
// - Test logic runs only on test clock
// - Port D pads 0-3 default to test
// - Line C12, D4, D5 default GPIO, per-line direction
module tps_top #(
	parameter int          DR_WIDTH = `TPS_DR_WIDTH,
	parameter logic [31:0] ID_CODE  = 32'h1000_0001 // Arbitrary value
) (
	input  wire logic                core_clk_in,
	input  wire logic                rst_b_in,
	input  wire logic                test_clk_in,
	input  wire tps_pkg::tps_test_in_s test_in,
	output logic                     test_do_out,
	output logic                     test_do_oe_out,
	input  wire logic [6:0]          pad_in,
	output tps_pkg::tps_gpio_s       gpio_out,
	input  wire logic [6:0]          core_dout_in,
	input  wire logic [6:0]          core_dir_in,
	output logic [6:0]               core_din_out,
	output logic                     test_mode_out,
	output logic                     stream_valid_out,
	input  wire logic                stream_ready_in,
	output logic [DR_WIDTH-1:0]      stream_data_out
);
	import tps_pkg::*;
	// -------------------------------------------------------------
	// Test clock domain
	// -------------------------------------------------------------
	tps_state_e                state, next_state;
	logic [`TPS_IR_WIDTH-1:0]  ir_sh, next_ir_sh, ir, next_ir;
	logic [`TPS_ID_WIDTH-1:0]  dr_sh, next_dr_sh;
	logic [`TPS_PINCTL_WIDTH-1:0] pinctl, next_pinctl;
	logic [DR_WIDTH-1:0]       word, next_word;
	logic                      tog, next_tog;
	logic                      do_q, next_do_q, oe_q, next_oe_q;
	logic                      tdi, tms;
	logic                      ack_t;
	assign tdi = test_in.tdi;
	assign tms = test_in.tms;
	// Pins sampled directly by the test clock; they are its own domain
	always_comb begin
		next_state = state;
		case (state)
		TPS_RESET:    next_state = tms ? TPS_RESET : TPS_IDLE;
		TPS_IDLE:     next_state = tms ? TPS_SEL_DR : TPS_IDLE;
		TPS_SEL_DR:   next_state = tms ? TPS_SEL_IR : TPS_CAP_DR;
		TPS_CAP_DR:   next_state = tms ? TPS_EXIT1_DR : TPS_SHIFT_DR;
		TPS_SHIFT_DR: next_state = tms ? TPS_EXIT1_DR : TPS_SHIFT_DR;
		TPS_EXIT1_DR: next_state = tms ? TPS_UPD_DR : TPS_PAUSE_DR;
		TPS_PAUSE_DR: next_state = tms ? TPS_EXIT2_DR : TPS_PAUSE_DR;
		TPS_EXIT2_DR: next_state = tms ? TPS_UPD_DR : TPS_SHIFT_DR;
		TPS_UPD_DR:   next_state = tms ? TPS_SEL_DR : TPS_IDLE;
		TPS_SEL_IR:   next_state = tms ? TPS_RESET : TPS_CAP_IR;
		TPS_CAP_IR:   next_state = tms ? TPS_EXIT1_IR : TPS_SHIFT_IR;
		TPS_SHIFT_IR: next_state = tms ? TPS_EXIT1_IR : TPS_SHIFT_IR;
		TPS_EXIT1_IR: next_state = tms ? TPS_UPD_IR : TPS_PAUSE_IR;
		TPS_PAUSE_IR: next_state = tms ? TPS_EXIT2_IR : TPS_PAUSE_IR;
		TPS_EXIT2_IR: next_state = tms ? TPS_UPD_IR : TPS_SHIFT_IR;
		TPS_UPD_IR:   next_state = tms ? TPS_SEL_DR : TPS_IDLE;
		default:      next_state = TPS_RESET;
		endcase
	end
	function automatic int dr_len(input logic [`TPS_IR_WIDTH-1:0] op);
		case (op)
		`TPS_IR_IDCODE: dr_len = `TPS_ID_WIDTH;
		`TPS_IR_SAMPLE: dr_len = 7;
		`TPS_IR_PINCTL: dr_len = `TPS_PINCTL_WIDTH;
		`TPS_IR_STREAM: dr_len = DR_WIDTH;
		default:        dr_len = 1;
		endcase
	endfunction : dr_len
	// Pads pass two test clock flops before the sample capture reads them.
	// With a gated clock the capture sees the pads of two edges earlier.
	logic [6:0] pad_t;
	tps_sync #(.WIDTH(7)) u_pad_tsync (
		.clk_in   (test_clk_in),
		.rst_b_in (rst_b_in),
		.d_in     (pad_in),
		.q_out    (pad_t)
	);
	logic stream_ack;
	always_comb begin
		int n;
		n           = dr_len(ir);
		next_ir_sh  = ir_sh;
		next_ir     = ir;
		next_dr_sh  = dr_sh;
		next_pinctl = pinctl;
		next_word   = word;
		next_tog    = tog;
		case (state)
		TPS_RESET: begin
			next_ir     = `TPS_IR_RESET;
			next_pinctl = `TPS_PINCTL_RESET;
		end
		TPS_CAP_IR:   next_ir_sh = `TPS_IR_WIDTH'(1);
		TPS_SHIFT_IR: next_ir_sh = {tdi, ir_sh[`TPS_IR_WIDTH-1:1]};
		TPS_UPD_IR:   next_ir = ir_sh;
		TPS_CAP_DR: begin
			case (ir)
			`TPS_IR_IDCODE: next_dr_sh = ID_CODE;
			`TPS_IR_SAMPLE: next_dr_sh = 32'(pad_t);
			`TPS_IR_PINCTL: next_dr_sh = 32'(pinctl);
			default:        next_dr_sh = '0;
			endcase
		end
		TPS_SHIFT_DR: begin
			next_dr_sh = dr_sh >> 1;
			next_dr_sh[n-1] = tdi;
		end
		TPS_UPD_DR: begin
			if (ir == `TPS_IR_PINCTL)
				next_pinctl = dr_sh[`TPS_PINCTL_WIDTH-1:0];
			// A word is dropped if the core has not taken the last one
			if (ir == `TPS_IR_STREAM && stream_ack) begin
				next_word = dr_sh[DR_WIDTH-1:0];
				next_tog  = ~tog;
			end
		end
		default: ;
		endcase
	end
	always_ff @(posedge test_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state  <= TPS_RESET;
			ir_sh  <= '0;
			ir     <= `TPS_IR_RESET;
			dr_sh  <= '0;
			pinctl <= `TPS_PINCTL_RESET;
			word   <= '0;
			tog    <= 1'b0;
		end else begin
			state  <= next_state;
			ir_sh  <= next_ir_sh;
			ir     <= next_ir;
			dr_sh  <= next_dr_sh;
			pinctl <= next_pinctl;
			word   <= next_word;
			tog    <= next_tog;
		end
	end
	// -------------------------------------------------------------
	// Data output, updated on the falling test clock edge
	// -------------------------------------------------------------
	always_comb begin
		next_oe_q = (state == TPS_SHIFT_IR) || (state == TPS_SHIFT_DR);
		if (state == TPS_SHIFT_IR)
			next_do_q = ir_sh[0];
		else if (state == TPS_SHIFT_DR)
			next_do_q = dr_sh[0];
		else
			next_do_q = do_q;
	end
	always_ff @(negedge test_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			do_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			do_q <= next_do_q;
			oe_q <= next_oe_q;
		end
	end
	assign test_do_out    = do_q;
	assign test_do_oe_out = oe_q;
	// Core acknowledge toggle returns to the test domain
	logic ack_tog;
	tps_sync #(.WIDTH(1)) u_ack_sync (
		.clk_in   (test_clk_in),
		.rst_b_in (rst_b_in),
		.d_in     (ack_tog),
		.q_out    (ack_t)
	);
	assign stream_ack = (ack_t == tog);
	// -------------------------------------------------------------
	// Core clock domain
	// -------------------------------------------------------------
	logic [6:0]  pad_s;
	logic        tog_s, tog_seen, next_tog_seen, next_ack_tog;
	logic [15:0] pinctl_s;
	logic        bin_valid, bin_ready;
	tps_sync #(.WIDTH(7)) u_pad_sync (
		.clk_in   (core_clk_in),
		.rst_b_in (rst_b_in),
		.d_in     (pad_in),
		.q_out    (pad_s)
	);
	tps_sync #(.WIDTH(1)) u_tog_sync (
		.clk_in   (core_clk_in),
		.rst_b_in (rst_b_in),
		.d_in     (tog),
		.q_out    (tog_s)
	);
	// Pin control changes only in update-DR and test reset, long before the word is read
	tps_sync #(.WIDTH(16)) u_ctl_sync (
		.clk_in   (core_clk_in),
		.rst_b_in (rst_b_in),
		.d_in     (pinctl),
		.q_out    (pinctl_s)
	);
	// A multi-bit word may land over two cycles; it is taken only when
	// two successive samples agree, so a half-changed word never hits a pad
	logic [15:0] pinctl_q, pinctl_c, next_pinctl_c;
	always_comb begin
		next_pinctl_c = (pinctl_s == pinctl_q) ? pinctl_s : pinctl_c;
	end
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pinctl_q <= `TPS_PINCTL_RESET;
			pinctl_c <= `TPS_PINCTL_RESET;
		end else begin
			pinctl_q <= pinctl_s;
			pinctl_c <= next_pinctl_c;
		end
	end
	assign bin_valid = (tog_s != tog_seen);
	always_comb begin
		next_tog_seen = (bin_valid && bin_ready) ? tog_s : tog_seen;
		next_ack_tog  = next_tog_seen;
	end
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tog_seen <= 1'b0;
			ack_tog  <= 1'b0;
		end else begin
			tog_seen <= next_tog_seen;
			ack_tog  <= next_ack_tog;
		end
	end
	tps_buf #(.WIDTH(DR_WIDTH), .DEPTH(`TPS_BUF_DEPTH)) u_buf (
		.clk_in        (core_clk_in),
		.rst_b_in      (rst_b_in),
		.in_valid_in   (bin_valid),
		.in_ready_out  (bin_ready),
		.in_data_in    (word),
		.out_valid_out (stream_valid_out),
		.out_ready_in  (stream_ready_in),
		.out_data_out  (stream_data_out)
	);
	// Pad mux: bits 3:0 of pin control hand pads D0..D3 to GPIO
	// Lines 6:4 (C12, D4, D5) are always GPIO from reset
	genvar g;
	generate
		for (g = 0; g < 7; g++) begin : g_pad
			logic gp;
			assign gp = (g >= 4) ? 1'b1 : pinctl_c[g];
			assign gpio_out.dout[g] = gp && core_dout_in[g];
			assign gpio_out.oe[g]   = gp && core_dir_in[g];
			assign gpio_out.din[g]  = gp ? pad_s[g] : 1'b0;
			assign core_din_out[g]  = gpio_out.din[g];
		end
	endgenerate
	assign test_mode_out = (pinctl_c[3:0] == 4'h0);
	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	property p_oe_shift;
		@(negedge test_clk_in) disable iff (!rst_b_in)
		1 |=> (oe_q == ($past(state) inside {TPS_SHIFT_IR, TPS_SHIFT_DR}));
	endproperty
	a_oe_shift: assert property (p_oe_shift)
		else $error("Data output enable outside shift state");
	property p_tms_reset;
		@(posedge test_clk_in) disable iff (!rst_b_in)
		tms [*5] |=> state == TPS_RESET;
	endproperty
	a_tms_reset: assert property (p_tms_reset)
		else $error("Five mode-select highs did not reset");
	property p_idle;
		@(posedge test_clk_in) disable iff (!rst_b_in)
		(state == TPS_RESET && !tms) |=> state == TPS_IDLE;
	endproperty
	a_idle: assert property (p_idle)
		else $error("Mode select low in reset did not reach idle");
	property p_ir_shift;
		@(posedge test_clk_in) disable iff (!rst_b_in)
		state == TPS_SHIFT_IR |=> ir_sh[`TPS_IR_WIDTH-1] == $past(tdi);
	endproperty
	a_ir_shift: assert property (p_ir_shift)
		else $error("Data input not shifted into instruction");
	property p_dr_shift;
		@(posedge test_clk_in) disable iff (!rst_b_in)
		(state == TPS_SHIFT_DR && ir == `TPS_IR_STREAM) |=>
			dr_sh[DR_WIDTH-1] == $past(tdi);
	endproperty
	a_dr_shift: assert property (p_dr_shift)
		else $error("Data input not shifted into stream word");
	property p_pads_test;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		test_mode_out |-> gpio_out.oe[3:0] == 4'h0;
	endproperty
	a_pads_test: assert property (p_pads_test)
		else $error("Test pad driven as GPIO");
	property p_gpio_dir;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		gpio_out.oe[6:4] == core_dir_in[6:4];
	endproperty
	a_gpio_dir: assert property (p_gpio_dir)
		else $error("Shared GPIO direction not followed");
	property p_pinctl_rst;
		@(posedge test_clk_in) disable iff (!rst_b_in)
		state == TPS_RESET |=> pinctl == `TPS_PINCTL_RESET;
	endproperty
	a_pinctl_rst: assert property (p_pinctl_rst)
		else $error("Pin control not restored in test reset");
endmodule : tps_top

// file: verilog/tps_regs.svh
// Constants for the test port and pin sharing block
`ifndef TPS_REGS_SVH
`define TPS_REGS_SVH
`define TPS_IR_WIDTH      4
`define TPS_IR_RESET      4'h1
`define TPS_IR_BYPASS     4'hf
`define TPS_IR_IDCODE     4'h1
`define TPS_IR_SAMPLE     4'h2
`define TPS_IR_PINCTL     4'h3
`define TPS_IR_STREAM     4'h4
`define TPS_DR_WIDTH      8
`define TPS_ID_WIDTH      32
`define TPS_PINCTL_WIDTH  16
`define TPS_PINCTL_RESET  16'h0000
`define TPS_GPIO_COUNT    7
`define TPS_BUF_DEPTH     2
`endif

// file: verilog/tps_pkg.sv
// Types for the test port and pin sharing block
package tps_pkg;
	typedef enum logic [3:0] {
		TPS_RESET, TPS_IDLE, TPS_SEL_DR, TPS_CAP_DR, TPS_SHIFT_DR,
		TPS_EXIT1_DR, TPS_PAUSE_DR, TPS_EXIT2_DR, TPS_UPD_DR,
		TPS_SEL_IR, TPS_CAP_IR, TPS_SHIFT_IR, TPS_EXIT1_IR,
		TPS_PAUSE_IR, TPS_EXIT2_IR, TPS_UPD_IR
	} tps_state_e;
	typedef struct packed {
		logic [6:0] din;
		logic [6:0] dout;
		logic [6:0] oe;
	} tps_gpio_s;
	typedef struct packed {
		logic       tdi;
		logic       tms;
	} tps_test_in_s;
endpackage : tps_pkg

// file: verilog/tps_buf.sv
// Two-entry valid/ready buffer
`timescale 1ns/1ps
module tps_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input  wire logic             clk_in,
	input  wire logic             rst_b_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      count, next_count;
	logic [AW-1:0]    wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic             push, pop;
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : bump
	assign in_ready_out  = (count != (AW+1)'(DEPTH));
	assign out_valid_out = (count != '0);
	assign push = in_valid_in && in_ready_out;
	assign pop  = out_valid_out && out_ready_in;
	always_comb begin
		next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
		next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
		next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			count  <= '0;
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			count  <= next_count;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end
	// Storage has no reset; only read through the valid flag
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end
	assign out_data_out = mem[rd_ptr];
endmodule : tps_buf

// file: verilog/tps_sync.sv
// Two-flop level synchroniser, one per bit
`timescale 1ns/1ps
module tps_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_in,
	input  wire logic             rst_b_in,
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] meta;
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta  <= '0;
			q_out <= '0;
		end else begin
			meta  <= d_in;
			q_out <= meta;
		end
	end
endmodule : tps_sync

// file: verif/tps_host.sv
// Host model that drives the test port pins
`timescale 1ns/1ps
module tps_host (
	output logic                  tck_out,
	output tps_pkg::tps_test_in_s tin_out,
	input  wire logic             tdo_in,
	input  wire logic             oe_in
);
	import tps_pkg::*;
	logic ok_oe, last_oe;
	initial begin
		tck_out = 1'b0;
		tin_out = '{tdi: 1'b1, tms: 1'b1};
	end
	// Clock runs only inside a frame
	task tick(input logic tms, input logic tdi, output logic tdo);
		tin_out = '{tdi: tdi, tms: tms};
		#40;
		// Released pad reads high through its pull-up
		tdo = oe_in ? tdo_in : 1'b1;
		last_oe = oe_in;
		tck_out = 1'b1;
		#40;
		tck_out = 1'b0;
	endtask : tick
	task idle();
		logic b;
		repeat (5) tick(1'b1, 1'b0, b);
		tick(1'b0, 1'b0, b);
	endtask : idle
	// From idle through one shift back to idle
	task shift(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic b;
		dout = '0;
		tick(1'b1, 1'b0, b);
		if (ir) tick(1'b1, 1'b0, b);
		tick(1'b0, 1'b0, b);
		tick(1'b0, 1'b0, b);
		ok_oe = 1'b1;
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], b);
			ok_oe = ok_oe & last_oe;
			dout[i] = b;
		end
		tick(1'b1, 1'b0, b);
		tick(1'b0, 1'b0, b);
	endtask : shift
endmodule : tps_host

// file: verif/test_port_pin_sharing_bench.sv
// Bench for the test port and pin sharing block
`timescale 1ns/1ps
module test_port_pin_sharing_bench;
	import tps_pkg::*;
	logic clk, rst_b, tck, tdo, oe, mode, sv, sr;
	tps_test_in_s tin;
	tps_gpio_s gpio;
	logic [6:0] pad, cdo, cdir, cdin;
	logic [7:0] sd;
	logic [31:0] d;
	int failures, n_tests, cyc;
	tps_top dut (.core_clk_in(clk), .rst_b_in(rst_b),
		.test_clk_in(tck), .test_in(tin), .test_do_out(tdo),
		.test_do_oe_out(oe), .pad_in(pad), .gpio_out(gpio),
		.core_dout_in(cdo), .core_dir_in(cdir), .core_din_out(cdin),
		.test_mode_out(mode), .stream_valid_out(sv),
		.stream_ready_in(sr), .stream_data_out(sd));
	tps_host host (.tck_out(tck), .tin_out(tin), .tdo_in(tdo),
		.oe_in(oe));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task final_report();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	task core(input logic [6:0] p, input logic [6:0] o,
		input logic [6:0] r);
		@(negedge clk);
		pad = p;
		cdo = o;
		cdir = r;
		repeat (5) @(negedge clk);
	endtask : core
	task t_reset();
		chk("mode", 1, mode);
		chk("do_oe", 0, oe);
		core(7'h7f, 7'h00, 7'h00);
		chk("din", 7'h70, cdin);
		$display("test reset done");
	endtask : t_reset
	task t_gpio();
		core(7'h00, 7'h10, 7'h50);
		chk("oe", 3'b101, gpio.oe[6:4]);
		chk("dout", 3'b001, gpio.dout[6:4]);
		$display("test gpio done");
	endtask : t_gpio
	task t_id();
		host.idle();
		host.shift(1'b0, 32, 32'h0, d);
		chk("id", 32'h1000_0001, d);
		chk("oe_shift", 1, host.ok_oe);
		#1 chk("oe_idle", 0, oe);
		$display("test idcode done");
	endtask : t_id
	task t_bypass();
		host.shift(1'b1, 4, 32'hf, d);
		chk("ir_cap", 4'h1, d[3:0]);
		host.shift(1'b0, 9, 32'h0a5, d);
		chk("bypass", 9'h14a, d[8:0]);
		$display("test bypass done");
	endtask : t_bypass
	task t_pin();
		host.shift(1'b1, 4, 32'h3, d);
		host.shift(1'b0, 16, 32'h000f, d);
		core(7'h0a, 7'h01, 7'h03);
		chk("mode", 0, mode);
		chk("din", 7'h0a, cdin);
		chk("oe", 7'h03, gpio.oe);
		chk("dout", 7'h01, gpio.dout);
		host.idle();
		core(7'h0a, 7'h0f, 7'h0f);
		chk("mode", 1, mode);
		chk("oe_test", 7'h00, gpio.oe);
		chk("din_test", 7'h00, cdin);
		$display("test pinctl done");
	endtask : t_pin
	task t_sample();
		core(7'h55, 7'h00, 7'h00);
		host.shift(1'b1, 4, 32'h2, d);
		host.shift(1'b0, 7, 32'h0, d);
		chk("sample", 7'h55, d[6:0]);
		$display("test sample done");
	endtask : t_sample
	task wait_v();
		for (int i = 0; i < 40 && sv !== 1'b1; i++) @(negedge clk);
	endtask : wait_v
	task pop(input logic [7:0] e);
		wait_v();
		chk("valid", 1, sv);
		chk("data", e, sd);
		sr = 1'b1;
		@(negedge clk);
		sr = 1'b0;
	endtask : pop
	task t_stream();
		host.shift(1'b1, 4, 32'h4, d);
		host.shift(1'b0, 8, 32'ha5, d);
		host.shift(1'b0, 8, 32'h3c, d);
		@(negedge clk);
		pop(8'ha5);
		pop(8'h3c);
		repeat (4) @(negedge clk);
		chk("empty", 0, sv);
		$display("test stream done");
	endtask : t_stream
	initial begin
		failures = 0;
		n_tests = 0;
		cyc = 0;
		rst_b = 1'b0;
		pad = '0;
		cdo = '0;
		cdir = '0;
		sr = 1'b0;
		host.idle();
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		repeat (2) @(negedge clk);
		t_reset();
		t_gpio();
		t_id();
		t_bypass();
		t_pin();
		t_sample();
		t_stream();
		final_report();
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			final_report();
		end
	end
endmodule : test_port_pin_sharing_bench
